//--- hw/drm_mapper.sv
// page-mode dram bank decode, row/column sequencing and apb config registers
//
// Added by the designer: the APB interface to the registers.
module drm_mapper (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic [drm_pkg::PAW-1:0]   paddr,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [drm_pkg::DW-1:0]    pwdata,
  output logic [drm_pkg::DW-1:0]         prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      req_valid,
  output logic                           req_ready,
  input  wire drm_pkg::drm_req_t         req,
  output logic                           resp_valid,
  output drm_pkg::drm_resp_t             resp,
  output logic [drm_pkg::MA_W-1:0]       mux_mem_addr,
  output logic [drm_pkg::NUM_BANKS-1:0]  bank_row_strobes_n,
  output logic                           col_strobe_n
);
  localparam int NB = drm_pkg::NUM_BANKS;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0]              cfg_lo_q, cfg_lo_d, cfg_mid_q, cfg_mid_d;
  logic [3:0]              cfg_hi_q, cfg_hi_d;
  logic [NB-1:0]           asym_q, asym_d;
  logic [drm_pkg::DW-1:0]  prdata_q, prdata_d;
  logic                    perr_q, perr_d;
  drm_pkg::drm_bank_cfg_t [NB-1:0] cfg_vec;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  drm_pkg::drm_state_t     st_q, st_d;
  logic [7:0]              cnt_q, cnt_d;
  logic [2:0]              bank_q, bank_d;
  logic [drm_pkg::MA_W-1:0] rowa_q, rowa_d, cola_q, cola_d;
  logic [NB-1:0]           open_q, open_d;
  logic [drm_pkg::MA_W-1:0] row_q [NB];
  logic [drm_pkg::MA_W-1:0] row_d [NB];
  logic [drm_pkg::MA_W-1:0] ma_q, ma_d;
  logic [NB-1:0]           ras_n_q, ras_n_d;
  logic                    cas_n_q, cas_n_d;
  logic                    resp_v_q, resp_v_d;
  drm_pkg::drm_resp_t      resp_q, resp_d;

  logic                    buf_valid, buf_ready;
  drm_pkg::drm_req_t       head;
  logic [3:0]              found;
  logic [2:0]              sel_bank;
  logic                    bank_ok, page_hit, pop;
  logic [drm_pkg::MA_W-1:0] map_row, map_col;

  // packed nibbles line up with {type, capacity} per bank
  assign cfg_vec = {cfg_hi_q, cfg_mid_q, cfg_lo_q};

  // first installed bank whose cumulative window holds the address
  function automatic logic [3:0] find_bank(
    input logic [11:0] mb,
    input drm_pkg::drm_bank_cfg_t [NB-1:0] c
  );
    logic [11:0] base;
    logic [11:0] top;
    logic [3:0]  r;
    base = '0;
    r    = '0;
    for (int i = 0; i < NB; i++) begin
      top = base + drm_pkg::size_mb(c[i].size);
      if (!r[3] && c[i].size != drm_pkg::SZ_NONE && mb >= base && mb < top) begin
        r = {1'b1, 3'(i)};
      end
      base = top;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // request buffer: a stalled sequencer backs up into req_ready
  // ----------------------------------------------------------------
  drm_fifo #(
    .W     ($bits(drm_pkg::drm_req_t)),
    .DEPTH (2)
  ) u_buf (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (req_valid),
    .in_ready  (req_ready),
    .in_data   (req),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (head)
  );

  // decode of the buffer head
  assign found    = find_bank(head.cpu_cycle_addr[drm_pkg::CA_MB_LO +: 12], cfg_vec);
  assign bank_ok  = found[3];
  assign sel_bank = found[2:0];
  assign buf_ready = (st_q == drm_pkg::S_IDLE);
  assign pop      = buf_valid & buf_ready;
  assign page_hit = bank_ok & open_q[sel_bank] & (row_q[sel_bank] == map_row);

  drm_addr_map u_map (
    .cpu_cycle_addr (head.cpu_cycle_addr),
    .cfg            (cfg_vec[sel_bank]),
    .asym_sel       (asym_q[sel_bank]),
    .row_addr       (map_row),
    .col_addr       (map_col)
  );

  // ----------------------------------------------------------------
  // sequencer next state: precharge on a miss to an open bank, row, ras, column, cas
  // ----------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    bank_d   = bank_q;
    rowa_d   = rowa_q;
    cola_d   = cola_q;
    open_d   = open_q;
    row_d    = row_q;
    ma_d     = ma_q;
    ras_n_d  = ras_n_q;
    cas_n_d  = 1'b1;
    resp_v_d = 1'b0;
    resp_d   = resp_q;
    case (st_q)
      drm_pkg::S_IDLE: begin
        if (buf_valid) begin
          bank_d      = sel_bank;
          rowa_d      = map_row;
          cola_d      = map_col;
          resp_d.bank = sel_bank;
          resp_d.hit  = page_hit;
          resp_d.err  = ~bank_ok;
          if (!bank_ok) begin
            resp_v_d = 1'b1;
          end else if (page_hit) begin
            st_d = drm_pkg::S_COL;
            ma_d = map_col;
          end else if (open_q[sel_bank]) begin
            st_d              = drm_pkg::S_PRE;
            ras_n_d[sel_bank] = 1'b1;
            open_d[sel_bank]  = 1'b0;
            cnt_d             = drm_pkg::TRP_CYC - 8'h01;
          end else begin
            st_d = drm_pkg::S_ROW;
            ma_d = map_row;
          end
        end
      end
      drm_pkg::S_PRE: begin
        if (cnt_q == 8'h00) begin
          st_d = drm_pkg::S_ROW;
          ma_d = rowa_q;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      drm_pkg::S_ROW: begin
        st_d            = drm_pkg::S_RAS;
        ras_n_d[bank_q] = 1'b0;
        open_d[bank_q]  = 1'b1;
        row_d[bank_q]   = rowa_q;
      end
      drm_pkg::S_RAS: begin
        st_d = drm_pkg::S_COL;
        ma_d = cola_q;
      end
      drm_pkg::S_COL: begin
        st_d    = drm_pkg::S_CAS;
        cas_n_d = 1'b0;
        cnt_d   = drm_pkg::CAS_CYC - 8'h01;
      end
      drm_pkg::S_CAS: begin
        if (cnt_q == 8'h00) begin
          st_d     = drm_pkg::S_IDLE;
          resp_v_d = 1'b1;
        end else begin
          cnt_d   = cnt_q - 8'h01;
          cas_n_d = 1'b0;
        end
      end
      default: st_d = drm_pkg::S_IDLE;
    endcase
  end

  // other banks keep their strobes, so pages stay open side by side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= drm_pkg::S_IDLE;
      cnt_q    <= '0;
      bank_q   <= '0;
      rowa_q   <= '0;
      cola_q   <= '0;
      open_q   <= '0;
      for (int i = 0; i < NB; i++) begin
        row_q[i] <= '0;
      end
      ma_q     <= '0;
      ras_n_q  <= '1;
      cas_n_q  <= 1'b1;
      resp_v_q <= 1'b0;
      resp_q   <= '0;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      bank_q   <= bank_d;
      rowa_q   <= rowa_d;
      cola_q   <= cola_d;
      open_q   <= open_d;
      row_q    <= row_d;
      ma_q     <= ma_d;
      ras_n_q  <= ras_n_d;
      cas_n_q  <= cas_n_d;
      resp_v_q <= resp_v_d;
      resp_q   <= resp_d;
    end
  end

  assign mux_mem_addr       = ma_q;
  assign bank_row_strobes_n = ras_n_q;
  assign col_strobe_n       = cas_n_q;
  assign resp_valid         = resp_v_q;
  assign resp               = resp_q;

  // ----------------------------------------------------------------
  // apb slave: data latched at setup, so access phase never waits
  // ----------------------------------------------------------------
  always_comb begin
    cfg_lo_d  = cfg_lo_q;
    cfg_mid_d = cfg_mid_q;
    cfg_hi_d  = cfg_hi_q;
    asym_d    = asym_q;
    prdata_d  = prdata_q;
    perr_d    = perr_q;
    if (psel && !penable) begin
      prdata_d = '0;
      perr_d   = (paddr[1:0] != 2'h0) || (paddr[11:10] != 2'h0);
      case (paddr[9:2])
        drm_pkg::IDX_CFG_LO:  prdata_d[7:0] = cfg_lo_q;
        drm_pkg::IDX_CFG_MID: prdata_d[7:0] = cfg_mid_q;
        drm_pkg::IDX_CFG_HI:  prdata_d[3:0] = cfg_hi_q;
        drm_pkg::IDX_ASYM:    prdata_d[NB-1:0] = asym_q;
        drm_pkg::IDX_STATUS: begin
          prdata_d[NB-1:0]          = open_q;
          prdata_d[drm_pkg::ST_BUSY] = (st_q != drm_pkg::S_IDLE) | buf_valid;
        end
        default: perr_d = 1'b1;
      endcase
    end
    if (psel && penable && pwrite && !perr_q) begin
      case (paddr[9:2])
        drm_pkg::IDX_CFG_LO:  cfg_lo_d  = pwdata[7:0];
        drm_pkg::IDX_CFG_MID: cfg_mid_d = pwdata[7:0];
        drm_pkg::IDX_CFG_HI:  cfg_hi_d  = pwdata[3:0];
        drm_pkg::IDX_ASYM:    asym_d    = pwdata[NB-1:0];
        default: cfg_hi_d = cfg_hi_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_lo_q  <= drm_pkg::RST_CFG;
      cfg_mid_q <= drm_pkg::RST_CFG;
      cfg_hi_q  <= drm_pkg::RST_CFG[3:0];
      asym_q    <= drm_pkg::RST_ASYM[NB-1:0];
      prdata_q  <= '0;
      perr_q    <= 1'b0;
    end else begin
      cfg_lo_q  <= cfg_lo_d;
      cfg_mid_q <= cfg_mid_d;
      cfg_hi_q  <= cfg_hi_d;
      asym_q    <= asym_d;
      prdata_q  <= prdata_d;
      perr_q    <= perr_d;
    end
  end

  assign pready  = psel & penable;
  assign prdata  = prdata_q;
  assign pslverr = psel & penable & perr_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ras_open_a: assert property (bank_row_strobes_n == ~open_q)
    else $error("row strobe does not match open page");
  hit_hold_a: assert property (pop && page_hit |=> $stable(bank_row_strobes_n) [*3])
    else $error("row strobe moved on page hit");
  cas_col_a: assert property (!col_strobe_n |-> mux_mem_addr == cola_q && st_q == drm_pkg::S_CAS)
    else $error("column strobe without column address");
  row_phase_a: assert property (st_q == drm_pkg::S_RAS |-> mux_mem_addr == rowa_q ##1 mux_mem_addr == cola_q)
    else $error("row then column order broken");
  sym_map_a: assert property (pop && !cfg_vec[sel_bank].asym |-> map_row[11:9] == {head.cpu_cycle_addr[24], head.cpu_cycle_addr[22], head.cpu_cycle_addr[20]} && map_col[9] == head.cpu_cycle_addr[21])
    else $error("symmetric mapping wrong");
  big_sym_a: assert property (pop && cfg_vec[sel_bank].size >= drm_pkg::SZ_32MB |-> map_row[9] == head.cpu_cycle_addr[20])
    else $error("large bank not symmetric");
  v0_1mb_a: assert property (pop && cfg_vec[sel_bank] == {1'b1, drm_pkg::SZ_1MB} && !asym_q[sel_bank] |-> map_row[9] == head.cpu_cycle_addr[10])
    else $error("variant 0 row line 9 wrong");
  v1_1mb_a: assert property (pop && cfg_vec[sel_bank] == {1'b1, drm_pkg::SZ_1MB} && asym_q[sel_bank] |-> map_row[10] == head.cpu_cycle_addr[9])
    else $error("variant 1 row line 10 wrong");
  miss_err_a: assert property (pop && !bank_ok |=> resp_valid && resp.err && bank_row_strobes_n == $past(bank_row_strobes_n))
    else $error("unmapped access not flagged");
  hit_done_a: assert property (pop && page_hit |-> ##4 resp_valid && resp.hit)
    else $error("page hit answer late");

  hit_c:  cover property (pop && page_hit);
  pre_c:  cover property (st_q == drm_pkg::S_PRE);
  err_c:  cover property (pop && !bank_ok);
  asym_c: cover property (pop && cfg_vec[sel_bank].asym && asym_q[sel_bank]);
endmodule

//--- common/drm_pkg.sv
// shared constants, register map and carrier types of the dram address mapper
package drm_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_BANKS = 5;
  localparam int MA_W      = 12;
  localparam int AW        = 32;
  localparam int DW        = 32;
  localparam int PAW       = 12;

  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CFG_LO  = 8'hA8;
  localparam logic [7:0] IDX_CFG_MID = 8'hA9;
  localparam logic [7:0] IDX_CFG_HI  = 8'hAA;
  localparam logic [7:0] IDX_ASYM    = 8'hD3;
  localparam logic [7:0] IDX_STATUS  = 8'hE0;
  localparam logic [7:0] RST_CFG     = 8'h00;
  localparam logic [7:0] RST_ASYM    = 8'h00;

  // ----------------------------------------------------------------
  // capacity codes and address fields
  // ----------------------------------------------------------------
  localparam logic [2:0] SZ_NONE = 3'h0;
  localparam logic [2:0] SZ_1MB  = 3'h1;
  localparam logic [2:0] SZ_2MB  = 3'h2;
  localparam logic [2:0] SZ_4MB  = 3'h3;
  localparam logic [2:0] SZ_8MB  = 3'h4;
  localparam logic [2:0] SZ_16MB = 3'h5;
  localparam logic [2:0] SZ_32MB = 3'h6;
  localparam int CA_COL_LO = 2;
  localparam int CA_ROW_LO = 11;
  localparam int CA_MB_LO  = 20;
  localparam int MA_LOW_W  = 9;
  localparam int ST_BUSY   = 8;

  // ----------------------------------------------------------------
  // sequencing counts in pclk cycles
  // ----------------------------------------------------------------
  localparam logic [7:0] TRP_CYC = 8'h02;
  localparam logic [7:0] CAS_CYC = 8'h02;

  typedef struct packed {
    logic       asym;
    logic [2:0] size;
  } drm_bank_cfg_t;

  typedef struct packed {
    logic [AW-1:0] cpu_cycle_addr;
  } drm_req_t;

  typedef struct packed {
    logic       hit;
    logic       err;
    logic [2:0] bank;
  } drm_resp_t;

  typedef enum logic [2:0] {S_IDLE, S_PRE, S_ROW, S_RAS, S_COL, S_CAS} drm_state_t;

  // capacity of a bank in 1MB units, zero when not installed
  function automatic logic [11:0] size_mb(input logic [2:0] code);
    return (code == SZ_NONE) ? 12'h000 : (12'h001 << (code - 3'h1));
  endfunction

endpackage

//--- hw/drm_fifo.sv
// small flip-flop fifo with valid/ready on both sides
module drm_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic          push, pop;

  function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // honest full/empty straight from the occupancy count
  assign in_ready  = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // next pointers, count and storage
  always_comb begin
    mem_d = mem_q;
    wr_d  = push ? nxt(wr_q) : wr_q;
    rd_d  = pop ? nxt(rd_q) : rd_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
    if (push) begin
      mem_d[wr_q] = in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

//--- hw/drm_addr_map.sv
// row and column address multiplexing for one bank setting
module drm_addr_map (
  input  wire logic [drm_pkg::AW-1:0]     cpu_cycle_addr,
  input  wire drm_pkg::drm_bank_cfg_t     cfg,
  input  wire logic                       asym_sel,
  output logic [drm_pkg::MA_W-1:0]        row_addr,
  output logic [drm_pkg::MA_W-1:0]        col_addr
);
  logic [31:0] a;
  logic        asym_eff;
  logic [2:0]  hi;

  assign a = cpu_cycle_addr;
  // 32MB and 64MB banks ignore both symmetry and variant bits
  assign asym_eff = cfg.asym & (cfg.size < drm_pkg::SZ_32MB);

  // column is the same for every mode; all twelve lines always driven
  assign col_addr = {a[25], a[23], a[21], a[drm_pkg::CA_COL_LO +: drm_pkg::MA_LOW_W]};

  // upper row lines 11..9 per capacity and variant
  always_comb begin
    hi = {a[24], a[22], a[20]};
    if (asym_eff) begin
      case (cfg.size)
        drm_pkg::SZ_1MB:  hi = asym_sel ? {a[24], a[9], a[10]} : {a[24], a[22], a[10]};
        drm_pkg::SZ_2MB:  hi = asym_sel ? {a[9], a[10], a[20]} : {a[24], a[10], a[20]};
        drm_pkg::SZ_4MB:  hi = asym_sel ? {a[10], a[21], a[20]} : {a[24], a[21], a[20]};
        drm_pkg::SZ_8MB:  hi = {a[21], a[22], a[20]};
        drm_pkg::SZ_16MB: hi = {a[23], a[22], a[20]};
        default:          hi = {a[24], a[22], a[20]};
      endcase
    end
  end

  assign row_addr = {hi, a[drm_pkg::CA_ROW_LO +: drm_pkg::MA_LOW_W]};
endmodule

//--- verification/drm_dram_model.sv
// behavioural page-mode dram banks that latch row and column on strobe falls
module drm_dram_model (
  input  wire logic                                        pclk,
  input  wire logic [drm_pkg::MA_W-1:0]                    mux_mem_addr,
  input  wire logic [drm_pkg::NUM_BANKS-1:0]               bank_row_strobes_n,
  input  wire logic                                        col_strobe_n,
  output logic [drm_pkg::NUM_BANKS-1:0][drm_pkg::MA_W-1:0] row_seen,
  output logic [drm_pkg::MA_W-1:0]                         col_seen,
  output int                                               row_opens
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle level of every strobe is high, so no false fall after reset
  logic [drm_pkg::NUM_BANKS-1:0]                   ras_prev = '1;
  logic                                            cas_prev = 1'b1;
  logic [drm_pkg::NUM_BANKS-1:0][drm_pkg::MA_W-1:0] rows_q   = '0;
  logic [drm_pkg::MA_W-1:0]                        col_q    = '0;
  int                                              opens_q  = 0;

  assign row_seen  = rows_q;
  assign col_seen  = col_q;
  assign row_opens = opens_q;

  // sampled on the clock: strobes and address move on the same edge, so a
  // plain edge detector on the strobe would race the address update;
  // each bank keeps its own open row, since several pages stay open at once
  always @(posedge pclk) begin
    ras_prev <= bank_row_strobes_n;
    cas_prev <= col_strobe_n;
    for (int i = 0; i < drm_pkg::NUM_BANKS; i++) begin
      if (ras_prev[i] && !bank_row_strobes_n[i]) begin
        rows_q[i] <= mux_mem_addr;
      end
    end
    if ((ras_prev & ~bank_row_strobes_n) != '0) begin
      opens_q <= opens_q + 1;
    end
    if (cas_prev && !col_strobe_n) begin
      col_q <= mux_mem_addr;
    end
  end
endmodule

//--- verification/drm_mapper_tb_top.sv
// self-checking bench of the dram address mapper
module drm_mapper_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic               pclk, presetn, psel, penable, pwrite, req_valid;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata;
  logic               pready, pslverr, req_ready, resp_valid, col_strobe_n;
  drm_pkg::drm_req_t  req;
  drm_pkg::drm_resp_t resp;
  logic [11:0]        mux_mem_addr, col_seen;
  logic [4:0][11:0]   row_seen;
  logic [4:0]         bank_row_strobes_n;
  int                 row_opens, err_count, num_checks, cycles, full_seen;
  drm_pkg::drm_resp_t rq[$];
  logic [4:0][11:0]   rowq[$];
  logic [11:0]        colq[$];
  // bank setup used by the scenarios: 1MB sym, 4MB v0, 2MB v1, 32MB, 8MB
  logic [2:0]         sz[5] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
  logic [4:0]         asy = 5'h1E;
  logic [4:0]         sel = 5'h1C;
  logic [31:0]        adr[5] = '{32'h000A5A5C, 32'h0035A5A4, 32'h005C3A58,
                                 32'h01F4B2C8, 32'h02A7C6E4};

  drm_mapper drm_mapper_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .resp_valid(resp_valid), .resp(resp), .mux_mem_addr(mux_mem_addr),
    .bank_row_strobes_n(bank_row_strobes_n), .col_strobe_n(col_strobe_n));
  drm_dram_model drm_dram_model_i (.pclk(pclk),
    .mux_mem_addr(mux_mem_addr), .bank_row_strobes_n(bank_row_strobes_n),
    .col_strobe_n(col_strobe_n), .row_seen(row_seen), .col_seen(col_seen),
    .row_opens(row_opens));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // collect answers with what the dram saw; timeout check stays last
  always @(posedge pclk) begin
    cycles++;
    if (req_valid && req_ready === 1'b0) full_seen++;
    if (resp_valid === 1'b1) begin
      rq.push_back(resp);
      rowq.push_back(row_seen);
      colq.push_back(col_seen);
    end
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [11:0] ra(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  // one apb transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic exp_er);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    chk("prdata", exp, rd);
    chk("pslverr", {31'h0, exp_er}, {31'h0, er});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
    chk("pslverr", 32'h0, {31'h0, er});
  endtask

  // raise a request and hold it until the accepting edge
  task automatic send(input logic [31:0] a);
    req_valid <= 1'b1;
    req <= a;
    do @(posedge pclk); while (req_ready !== 1'b1);
  endtask

  task automatic wait_resp(input int n);
    while (rq.size() < n) @(posedge pclk);
  endtask

  function automatic logic [11:0] exp_row(input logic [31:0] a, input logic [2:0] b);
    logic [2:0] u;
    u = {a[24], a[22], a[20]};
    if (asy[b] && sz[b] <= drm_pkg::SZ_16MB) begin
      case ({sel[b], sz[b]})
        4'h1: u = {a[24], a[22], a[10]};
        4'h2: u = {a[24], a[10], a[20]};
        4'h3: u = {a[24], a[21], a[20]};
        4'h9: u = {a[24], a[9], a[10]};
        4'hA: u = {a[9], a[10], a[20]};
        4'hB: u = {a[10], a[21], a[20]};
        4'h4, 4'hC: u = {a[21], a[22], a[20]};
        default: u = {a[23], a[22], a[20]};
      endcase
    end
    return {u, a[19:11]};
  endfunction

  task automatic chk_acc(input logic [2:0] b, input logic [31:0] a, input logic hit);
    drm_pkg::drm_resp_t r;
    logic [4:0][11:0]   rv;
    r = rq.pop_front();
    rv = rowq.pop_front();
    chk("resp", {27'h0, hit, 1'b0, b}, 32'(r));
    chk("row", 32'(exp_row(a, b)), 32'(rv[b]));
    chk("col", 32'({a[25], a[23], a[21], a[10:2]}), 32'(colq.pop_front()));
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_reset();
    chk("strobes", 32'h1F, 32'(bank_row_strobes_n));
    chk("col_strobe_n", 32'h1, 32'(col_strobe_n));
    chk("mux_mem_addr", 32'h0, 32'(mux_mem_addr));
    rdc(ra(drm_pkg::IDX_CFG_LO), 32'h0, 1'b0);
    rdc(ra(drm_pkg::IDX_ASYM), 32'h0, 1'b0);
    rdc(12'h3FC, 32'h0, 1'b1);
  endtask

  task automatic s_config();
    wr(ra(drm_pkg::IDX_CFG_LO), 32'hB1);
    wr(ra(drm_pkg::IDX_CFG_MID), 32'hEA);
    wr(ra(drm_pkg::IDX_CFG_HI), 32'hFC);
    wr(ra(drm_pkg::IDX_ASYM), 32'hFC);
    rdc(ra(drm_pkg::IDX_CFG_MID), 32'hEA, 1'b0);
    rdc(ra(drm_pkg::IDX_CFG_HI), 32'h0C, 1'b0);
    rdc(ra(drm_pkg::IDX_ASYM), 32'h1C, 1'b0);
  endtask

  // one closed-bank access per bank; 32MB bank must ignore its asym bits
  task automatic s_map();
    for (int b = 0; b < 5; b++) begin
      send(adr[b]);
      req_valid <= 1'b0;
      wait_resp(1);
      chk_acc(3'(b), adr[b], 1'b0);
    end
    chk("open strobes", 32'h0, 32'(bank_row_strobes_n));
    rdc(ra(drm_pkg::IDX_STATUS), 32'h1F, 1'b0);
  endtask

  // same row twice then a new row in bank 1
  task automatic s_hit();
    int opens;
    opens = row_opens;
    send(adr[1] ^ 32'h7FC);
    req_valid <= 1'b0;
    wait_resp(1);
    chk_acc(3'h1, adr[1] ^ 32'h7FC, 1'b1);
    chk("row opens", 32'(opens), 32'(row_opens));
    chk("bank1 open", 32'h0, 32'(bank_row_strobes_n[1]));
    send(adr[1] ^ 32'h800);
    req_valid <= 1'b0;
    wait_resp(1);
    chk_acc(3'h1, adr[1] ^ 32'h800, 1'b0);
    chk("row opens", 32'(opens + 1), 32'(row_opens));
  endtask

  // back-to-back burst fills the buffer, with an out-of-range address inside
  task automatic s_burst();
    drm_pkg::drm_resp_t r;
    full_seen = 0;
    send(32'h00011110);
    send(32'h00022220);
    send(32'h03000000);
    send(32'h00033330);
    req_valid <= 1'b0;
    wait_resp(4);
    chk("buffer full", 32'h1, 32'(full_seen > 0));
    chk_acc(3'h0, 32'h00011110, 1'b0);
    chk_acc(3'h0, 32'h00022220, 1'b0);
    r = rq.pop_front();
    void'(rowq.pop_front());
    void'(colq.pop_front());
    chk("err", 32'h1, 32'(r.err));
    chk_acc(3'h0, 32'h00033330, 1'b0);
  endtask

  // bank 0 becomes a 1MB asymmetric bank, first variant 0 then variant 1
  task automatic s_asym();
    wr(ra(drm_pkg::IDX_CFG_LO), 32'hB9);
    asy[0] = 1'b1;
    send(32'h00044404);
    req_valid <= 1'b0;
    wait_resp(1);
    chk_acc(3'h0, 32'h00044404, 1'b0);
    wr(ra(drm_pkg::IDX_ASYM), 32'h1D);
    sel[0] = 1'b1;
    send(32'h00055200);
    req_valid <= 1'b0;
    wait_resp(1);
    chk_acc(3'h0, 32'h00055200, 1'b0);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    req_valid = 1'b0;
    req = '0;
    presetn = 1'b0;
    err_count = 0;
    num_checks = 0;
    cycles = 0;
    full_seen = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    s_reset();
    s_config();
    s_map();
    s_hit();
    s_burst();
    s_asym();
    finish_test();
  end
endmodule
